// [common/mpil_pkg.sv]
// package for the machine panel interlock logic: register map, fields, timing
package mpil_pkg;
  // avalon word addresses (byte address / 4)
  localparam logic [3:0] MPIL_ADDR_CTRL = 4'h0;
  localparam logic [3:0] MPIL_ADDR_ESTOP_MASK = 4'h1;
  localparam logic [3:0] MPIL_ADDR_RESET_CFG = 4'h2;
  localparam logic [3:0] MPIL_ADDR_OT_CFG = 4'h3;
  localparam logic [3:0] MPIL_ADDR_TAP_TMO = 4'h4;
  localparam logic [3:0] MPIL_ADDR_POS_TMO = 4'h5;
  localparam logic [3:0] MPIL_ADDR_STATUS = 4'h6;
  localparam logic [3:0] MPIL_ADDR_IRQ_STAT = 4'h7;
  localparam logic [3:0] MPIL_ADDR_IRQ_MASK = 4'h8;
  // field positions
  localparam int MPIL_ESTOP_IGNORE_BIT = 3;
  localparam int MPIL_RESET_KEY_ENABLE = 0;
  localparam int MPIL_OT_POLARITY = 0;
  localparam int MPIL_OT_CHECK_ENABLE = 6;
  // reset values
  localparam logic [7:0] MPIL_ESTOP_MASK_RST = 8'h00;
  localparam logic [7:0] MPIL_RESET_CFG_RST = 8'h01;
  localparam logic [7:0] MPIL_OT_CFG_RST = 8'h41;
  // timeouts in ms at 25 MHz
  localparam int MPIL_CLK_HZ = 25000000;
  localparam int MPIL_TMO_MS_RST = 1000;
  localparam int MPIL_CYC_PER_MS = MPIL_CLK_HZ / 1000;
  localparam logic [15:0] MPIL_TMO_RST = 16'(MPIL_TMO_MS_RST);
  // irq event bits
  localparam int MPIL_EV_ESTOP = 0;
  localparam int MPIL_EV_OT = 1;
  localparam int MPIL_EV_TAP_TMO = 2;
  localparam int MPIL_EV_POS_TMO = 3;
  localparam int MPIL_EV_TAP_DONE = 4;
  localparam int MPIL_EV_POS_DONE = 5;
  localparam int MPIL_NEV = 6;
  typedef enum logic [2:0] {
    MPIL_TAP_IDLE = 3'b001,
    MPIL_TAP_WAIT = 3'b010,
    MPIL_TAP_DONE = 3'b100
  } mpil_tap_e;
  typedef enum logic [2:0] {
    MPIL_POS_IDLE = 3'b001,
    MPIL_POS_WAIT = 3'b010,
    MPIL_POS_DONE = 3'b100
  } mpil_pos_e;
endpackage

// [rtl/mpil_top.sv]
// machine panel interlock logic: stops, overtravel, lamp, tapping and exact stop handshakes
`timescale 1ns/1ns
module mpil_top
  import mpil_pkg::*;
#(
  parameter int CYC_PER_MS = MPIL_CYC_PER_MS
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  output logic IRQ_OUT,
  // mode and panel keys
  input wire logic MODE_AUTO_IN,
  input wire logic MODE_MDI_IN,
  input wire logic MODE_DNC_IN,
  input wire logic MODE_MANUAL_IN,
  input wire logic MODE_HANDWHEEL_IN,
  input wire logic OPT_STOP_KEY_IN,
  input wire logic CYCLE_START_KEY_IN,
  input wire logic RESET_KEY_IN,
  input wire logic PROGRAM_RUNNING_IN,
  input wire logic OPTIONAL_STOP_CODE_IN,
  input wire logic RIGID_TAPPING_CODE_IN,
  input wire logic EXACT_STOP_CODE_IN,
  input wire logic SPINDLE_CW_CMD_IN,
  input wire logic SPINDLE_CCW_CMD_IN,
  input wire logic SYSTEM_ALARM_IN,
  // machine side inputs
  input wire logic EMERGENCY_STOP_IN,
  input wire logic X_NEG_LIMIT_IN,
  input wire logic X_POS_LIMIT_IN,
  input wire logic Y_NEG_LIMIT_IN,
  input wire logic Y_POS_LIMIT_IN,
  input wire logic Z_NEG_LIMIT_IN,
  input wire logic Z_POS_LIMIT_IN,
  input wire logic SPINDLE_POSITION_STATE_IN,
  input wire logic POSITIONING_DONE_IN,
  input wire logic HANDWHEEL_SEL_X_IN,
  input wire logic HANDWHEEL_SEL_Y_IN,
  input wire logic HANDWHEEL_SEL_Z_IN,
  input wire logic HANDWHEEL_STEP_X1_IN,
  input wire logic HANDWHEEL_STEP_X10_IN,
  input wire logic HANDWHEEL_STEP_X100_IN,
  // outputs to panel, drive and core
  output logic OPT_STOP_LAMP_OUT,
  output logic PROGRAM_HALT_OUT,
  output logic SYSTEM_RESET_OUT,
  output logic CURSOR_RETURN_OUT,
  output logic EMERGENCY_ALARM_OUT,
  output logic OVERTRAVEL_ALARM_OUT,
  output logic DRIVE_ENABLE_OUT,
  output logic LAMP_YELLOW_OUT,
  output logic LAMP_GREEN_OUT,
  output logic LAMP_RED_OUT,
  output logic SPEED_POSITION_SWITCH_OUT,
  output logic RIGID_TAPPING_OUT,
  output logic TAPPING_DONE_FLAG_OUT,
  output logic TAPPING_TIMEOUT_ALARM_OUT,
  output logic POSITIONING_START_OUT,
  output logic POSITIONING_TIMEOUT_ALARM_OUT,
  output logic SPINDLE_CW_OUT,
  output logic SPINDLE_CCW_OUT,
  output logic [2:0] HANDWHEEL_AXIS_OUT,
  output logic [6:0] HANDWHEEL_STEP_OUT
);

  typedef struct packed {
    logic [7:0] estop_mask;
    logic [7:0] reset_cfg;
    logic [7:0] ot_cfg;
    logic [15:0] tap_tmo;
    logic [15:0] pos_tmo;
    logic [MPIL_NEV-1:0] irq_stat;
    logic [MPIL_NEV-1:0] irq_mask;
    logic [31:0] rdata;
    logic ack;
    logic opt_stop;
    logic halt;
    logic ot_alarm;
    logic estop_alarm;
    logic sys_reset;
    logic cursor_ret;
    logic tap_tmo_alarm;
    logic pos_tmo_alarm;
    mpil_tap_e tap_st;
    mpil_pos_e pos_st;
    logic [31:0] tap_cnt;
    logic [31:0] pos_cnt;
    logic spin_cw;
    logic spin_ccw;
    logic [2:0] hw_axis;
    logic [6:0] hw_step;
    logic opt_key_prev;
    logic reset_key_prev;
  } mpil_state_s;

  mpil_state_s s_q;
  mpil_state_s s_d;

  logic prog_mode;
  logic [5:0] limits;
  logic [5:0] lim_active;
  logic lim_any;
  logic estop_open;
  logic reset_press;
  logic [MPIL_NEV-1:0] events;
  logic [31:0] tap_limit;
  logic [31:0] pos_limit;
  logic rd_stat;

  assign prog_mode = MODE_AUTO_IN | MODE_MDI_IN | MODE_DNC_IN;
  assign limits = {Z_POS_LIMIT_IN, Z_NEG_LIMIT_IN, Y_POS_LIMIT_IN, Y_NEG_LIMIT_IN, X_POS_LIMIT_IN, X_NEG_LIMIT_IN};
  // polarity 1: alarm on open (low) input, 0: alarm on +24v (high)
  assign lim_active = s_q.ot_cfg[MPIL_OT_POLARITY] ? ~limits : limits;
  assign lim_any = s_q.ot_cfg[MPIL_OT_CHECK_ENABLE] & (|lim_active);
  assign estop_open = ~EMERGENCY_STOP_IN & ~s_q.estop_mask[MPIL_ESTOP_IGNORE_BIT];
  assign reset_press = RESET_KEY_IN & ~s_q.reset_key_prev & s_q.reset_cfg[MPIL_RESET_KEY_ENABLE];
  assign tap_limit = s_q.tap_tmo * 32'(CYC_PER_MS);
  assign pos_limit = s_q.pos_tmo * 32'(CYC_PER_MS);
  assign rd_stat = AVS_READ_IN & ~s_q.ack & (AVS_ADDRESS_IN == MPIL_ADDR_IRQ_STAT);

  always_comb begin
    s_d = s_q;
    events = '0;
    s_d.opt_key_prev = OPT_STOP_KEY_IN;
    s_d.reset_key_prev = RESET_KEY_IN;
    s_d.sys_reset = 1'b0;
    s_d.cursor_ret = 1'b0;
    // optional stop toggled by key, only in program modes
    if (OPT_STOP_KEY_IN && !s_q.opt_key_prev && prog_mode) begin
      s_d.opt_stop = ~s_q.opt_stop;
    end
    if (s_q.opt_stop && OPTIONAL_STOP_CODE_IN) begin
      s_d.halt = 1'b1;
    end
    if (s_q.halt && CYCLE_START_KEY_IN) begin
      s_d.halt = 1'b0;
    end
    // emergency
    if (estop_open) begin
      s_d.estop_alarm = 1'b1;
      events[MPIL_EV_ESTOP] = ~s_q.estop_alarm;
    end
    if (lim_any) begin
      s_d.ot_alarm = 1'b1;
      events[MPIL_EV_OT] = ~s_q.ot_alarm;
    end
    if (reset_press) begin
      // overtravel and estop alarms clear only once the cause is gone
      if (!lim_any) begin
        s_d.ot_alarm = 1'b0;
      end
      if (!estop_open) begin
        s_d.estop_alarm = 1'b0;
      end
      s_d.tap_tmo_alarm = 1'b0;
      s_d.pos_tmo_alarm = 1'b0;
      s_d.halt = 1'b0;
      if (MODE_AUTO_IN) begin
        s_d.sys_reset = 1'b1;
        s_d.cursor_ret = 1'b1;
      end
    end
    // rigid tapping handshake
    case (s_q.tap_st)
      MPIL_TAP_IDLE: begin
        s_d.tap_cnt = '0;
        if (RIGID_TAPPING_CODE_IN) begin
          s_d.tap_st = MPIL_TAP_WAIT;
        end
      end
      MPIL_TAP_WAIT: begin
        s_d.tap_cnt = s_q.tap_cnt + 32'h1;
        if (SPINDLE_POSITION_STATE_IN) begin
          s_d.tap_st = MPIL_TAP_DONE;
          events[MPIL_EV_TAP_DONE] = 1'b1;
        end else if (s_q.tap_cnt >= tap_limit) begin
          s_d.tap_tmo_alarm = 1'b1;
          events[MPIL_EV_TAP_TMO] = 1'b1;
          s_d.tap_st = MPIL_TAP_IDLE;
        end
      end
      MPIL_TAP_DONE: begin
        if (!RIGID_TAPPING_CODE_IN) begin
          s_d.tap_st = MPIL_TAP_IDLE;
        end
      end
      default: s_d.tap_st = MPIL_TAP_IDLE;
    endcase
    // exact stop handshake, speed mode means no tapping switch active
    case (s_q.pos_st)
      MPIL_POS_IDLE: begin
        s_d.pos_cnt = '0;
        if (EXACT_STOP_CODE_IN && s_q.tap_st == MPIL_TAP_IDLE) begin
          s_d.pos_st = MPIL_POS_WAIT;
          s_d.spin_cw = 1'b0;
          s_d.spin_ccw = 1'b0;
        end
      end
      MPIL_POS_WAIT: begin
        s_d.pos_cnt = s_q.pos_cnt + 32'h1;
        if (POSITIONING_DONE_IN) begin
          s_d.pos_st = MPIL_POS_DONE;
          events[MPIL_EV_POS_DONE] = 1'b1;
        end else if (s_q.pos_cnt >= pos_limit) begin
          s_d.pos_tmo_alarm = 1'b1;
          events[MPIL_EV_POS_TMO] = 1'b1;
          s_d.pos_st = MPIL_POS_IDLE;
        end
      end
      MPIL_POS_DONE: ;
      default: s_d.pos_st = MPIL_POS_IDLE;
    endcase
    // rotation command cancels exact stop only once the exact stop code is dropped
    if (s_q.pos_st == MPIL_POS_IDLE || !EXACT_STOP_CODE_IN) begin
      if (SPINDLE_CW_CMD_IN || SPINDLE_CCW_CMD_IN) begin
        s_d.pos_st = MPIL_POS_IDLE;
        s_d.spin_cw = SPINDLE_CW_CMD_IN;
        s_d.spin_ccw = SPINDLE_CCW_CMD_IN & ~SPINDLE_CW_CMD_IN;
      end
    end
    if (s_q.tap_st != MPIL_TAP_IDLE) begin
      s_d.spin_cw = 1'b0;
      s_d.spin_ccw = 1'b0;
    end
    // handwheel selects; one hot axis, step decoded to 1/10/100
    s_d.hw_axis = {HANDWHEEL_SEL_Z_IN, HANDWHEEL_SEL_Y_IN, HANDWHEEL_SEL_X_IN};
    if (HANDWHEEL_STEP_X100_IN) begin
      s_d.hw_step = 7'd100;
    end else if (HANDWHEEL_STEP_X10_IN) begin
      s_d.hw_step = 7'd10;
    end else if (HANDWHEEL_STEP_X1_IN) begin
      s_d.hw_step = 7'd1;
    end else begin
      s_d.hw_step = 7'd0;
    end
    // bus slave, one wait cycle per access
    s_d.ack = (AVS_READ_IN | AVS_WRITE_IN) & ~s_q.ack;
    if (AVS_WRITE_IN && !s_q.ack) begin
      case (AVS_ADDRESS_IN)
        MPIL_ADDR_ESTOP_MASK: s_d.estop_mask = AVS_WRITEDATA_IN[7:0];
        MPIL_ADDR_RESET_CFG: s_d.reset_cfg = AVS_WRITEDATA_IN[7:0];
        MPIL_ADDR_OT_CFG: s_d.ot_cfg = AVS_WRITEDATA_IN[7:0];
        MPIL_ADDR_TAP_TMO: s_d.tap_tmo = AVS_WRITEDATA_IN[15:0];
        MPIL_ADDR_POS_TMO: s_d.pos_tmo = AVS_WRITEDATA_IN[15:0];
        MPIL_ADDR_IRQ_MASK: s_d.irq_mask = AVS_WRITEDATA_IN[MPIL_NEV-1:0];
        default: ;
      endcase
    end
    if (AVS_READ_IN && !s_q.ack) begin
      case (AVS_ADDRESS_IN)
        MPIL_ADDR_CTRL: s_d.rdata = {29'h0, s_q.halt, s_q.opt_stop, DRIVE_ENABLE_OUT};
        MPIL_ADDR_ESTOP_MASK: s_d.rdata = {24'h0, s_q.estop_mask};
        MPIL_ADDR_RESET_CFG: s_d.rdata = {24'h0, s_q.reset_cfg};
        MPIL_ADDR_OT_CFG: s_d.rdata = {24'h0, s_q.ot_cfg};
        MPIL_ADDR_TAP_TMO: s_d.rdata = {16'h0, s_q.tap_tmo};
        MPIL_ADDR_POS_TMO: s_d.rdata = {16'h0, s_q.pos_tmo};
        MPIL_ADDR_STATUS: s_d.rdata = {24'h0, s_q.tap_st == MPIL_TAP_DONE, s_q.pos_st == MPIL_POS_DONE,
          s_q.pos_tmo_alarm, s_q.tap_tmo_alarm, s_q.ot_alarm, s_q.estop_alarm, 2'h0};
        MPIL_ADDR_IRQ_STAT: s_d.rdata = {26'h0, s_q.irq_stat};
        MPIL_ADDR_IRQ_MASK: s_d.rdata = {26'h0, s_q.irq_mask};
        default: s_d.rdata = 32'h0;
      endcase
    end
    // read clears; a same-cycle event still sets
    s_d.irq_stat = (rd_stat ? '0 : s_q.irq_stat) | events;
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      s_q <= '0;
      s_q.estop_mask <= MPIL_ESTOP_MASK_RST;
      s_q.reset_cfg <= MPIL_RESET_CFG_RST;
      s_q.ot_cfg <= MPIL_OT_CFG_RST;
      s_q.tap_tmo <= MPIL_TMO_RST;
      s_q.pos_tmo <= MPIL_TMO_RST;
      s_q.tap_st <= MPIL_TAP_IDLE;
      s_q.pos_st <= MPIL_POS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign AVS_READDATA_OUT = s_q.rdata;
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~s_q.ack;
  assign IRQ_OUT = |(s_q.irq_stat & s_q.irq_mask);
  assign OPT_STOP_LAMP_OUT = s_q.opt_stop;
  assign PROGRAM_HALT_OUT = s_q.halt;
  assign SYSTEM_RESET_OUT = s_q.sys_reset;
  assign CURSOR_RETURN_OUT = s_q.cursor_ret;
  assign EMERGENCY_ALARM_OUT = s_q.estop_alarm;
  assign OVERTRAVEL_ALARM_OUT = s_q.ot_alarm;
  assign DRIVE_ENABLE_OUT = ~s_q.estop_alarm;
  // red wins over green so an estop, overtravel or timeout alarm is never hidden
  assign LAMP_RED_OUT = s_q.estop_alarm | s_q.ot_alarm | s_q.tap_tmo_alarm | s_q.pos_tmo_alarm;
  assign LAMP_GREEN_OUT = ~LAMP_RED_OUT & PROGRAM_RUNNING_IN & MODE_AUTO_IN & ~SYSTEM_ALARM_IN;
  assign LAMP_YELLOW_OUT = ~LAMP_RED_OUT & ~LAMP_GREEN_OUT & ~SYSTEM_ALARM_IN;
  assign SPEED_POSITION_SWITCH_OUT = s_q.tap_st != MPIL_TAP_IDLE;
  assign RIGID_TAPPING_OUT = s_q.tap_st == MPIL_TAP_DONE;
  assign TAPPING_DONE_FLAG_OUT = s_q.tap_st == MPIL_TAP_DONE;
  assign TAPPING_TIMEOUT_ALARM_OUT = s_q.tap_tmo_alarm;
  assign POSITIONING_START_OUT = s_q.pos_st == MPIL_POS_WAIT;
  assign POSITIONING_TIMEOUT_ALARM_OUT = s_q.pos_tmo_alarm;
  assign SPINDLE_CW_OUT = s_q.spin_cw;
  assign SPINDLE_CCW_OUT = s_q.spin_ccw;
  assign HANDWHEEL_AXIS_OUT = s_q.hw_axis;
  assign HANDWHEEL_STEP_OUT = s_q.hw_step;

  AST_DRIVE_OFF: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    estop_open |=> !DRIVE_ENABLE_OUT) else $error("drive enable not dropped");
  AST_ESTOP_MASKED: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (!EMERGENCY_STOP_IN && s_q.estop_mask[MPIL_ESTOP_IGNORE_BIT] && !s_q.estop_alarm) |=> !s_q.estop_alarm)
    else $error("masked estop raised alarm");
  AST_OT_DISABLED: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (!s_q.ot_cfg[MPIL_OT_CHECK_ENABLE] && !s_q.ot_alarm) |=> !s_q.ot_alarm) else $error("ot when disabled");
  AST_OT_SENSE: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_q.ot_cfg[MPIL_OT_CHECK_ENABLE] && (|(limits ^ {6{s_q.ot_cfg[MPIL_OT_POLARITY]}}))) |=> s_q.ot_alarm)
    else $error("ot not raised");
  AST_OT_HOLD: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_q.ot_alarm && !reset_press) |=> s_q.ot_alarm) else $error("ot dropped without reset");
  AST_TAP_SAME: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_q.tap_st == MPIL_TAP_WAIT && SPINDLE_POSITION_STATE_IN) |=> (RIGID_TAPPING_OUT && TAPPING_DONE_FLAG_OUT))
    else $error("tap output and flag not together");
  AST_TAP_START: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_q.tap_st == MPIL_TAP_IDLE && RIGID_TAPPING_CODE_IN) |=> SPEED_POSITION_SWITCH_OUT)
    else $error("switch not asserted");
  AST_TAP_TMO: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $rose(TAPPING_TIMEOUT_ALARM_OUT) |-> $past(s_q.tap_cnt) >= $past(tap_limit)) else $error("early tap timeout");
  AST_POS_TMO: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $rose(POSITIONING_TIMEOUT_ALARM_OUT) |-> $past(POSITIONING_START_OUT)) else $error("pos timeout w/o start");
  AST_EXCL: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    POSITIONING_START_OUT |-> !(SPINDLE_CW_OUT || SPINDLE_CCW_OUT)) else $error("rotation during exact stop");
  AST_RESET_GATE: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (!s_q.reset_cfg[MPIL_RESET_KEY_ENABLE]) |=> !SYSTEM_RESET_OUT) else $error("reset while disabled");
  AST_LAMP: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    OVERTRAVEL_ALARM_OUT |-> (LAMP_RED_OUT && !LAMP_GREEN_OUT && !LAMP_YELLOW_OUT)) else $error("lamp not red");
  AST_HALT_SET: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_q.opt_stop && OPTIONAL_STOP_CODE_IN && !CYCLE_START_KEY_IN && !reset_press) |=> PROGRAM_HALT_OUT)
    else $error("optional stop did not halt");
  AST_CURSOR: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (reset_press && MODE_AUTO_IN) |=> (SYSTEM_RESET_OUT && CURSOR_RETURN_OUT)) else $error("no reset pulse");
  AST_SPEED_ONLY: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $rose(POSITIONING_START_OUT) |-> ($past(s_q.tap_st) == MPIL_TAP_IDLE)) else $error("exact stop in position mode");
  COV_TAP: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN) $rose(TAPPING_DONE_FLAG_OUT));
  COV_POS: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN) $rose(POSITIONING_TIMEOUT_ALARM_OUT));
  COV_OT: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN) $fell(OVERTRAVEL_ALARM_OUT));
  COV_HALT: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN) $fell(PROGRAM_HALT_OUT));
  COV_ESTOP: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN) $rose(EMERGENCY_ALARM_OUT));

endmodule // mpil_top

// [test/mpil_drive_model.sv]
// behavioural servo spindle drive answering the tapping and positioning handshakes
`timescale 1ns/1ns
module mpil_drive_model (
  input wire logic clk_in,
  input wire logic answer_en_in,
  input wire logic [2:0] delay_in,
  input wire logic switch_in,
  input wire logic start_in,
  output logic position_state_out,
  output logic done_out
);
  int sw_cnt = 0;
  int st_cnt = 0;
  initial begin
    position_state_out = 1'b0;
    done_out = 1'b0;
  end
  // answers stand only while the request stands; answer_en low models a dead drive
  always @(posedge clk_in) begin
    sw_cnt <= switch_in ? sw_cnt + 1 : 0;
    st_cnt <= start_in ? st_cnt + 1 : 0;
    position_state_out <= answer_en_in && switch_in && sw_cnt >= int'(delay_in);
    done_out <= answer_en_in && start_in && st_cnt >= int'(delay_in);
  end
endmodule // mpil_drive_model

// [test/test_mpil_top.sv]
// self-checking bench for the machine panel interlock logic
`timescale 1ns/1ns
module test_mpil_top;
  import mpil_pkg::*;
  logic clk = 0, rst = 1, rd = 0, wr = 0, wait_r, irq, ans_en = 1, pos_state, pos_done;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic auto_m = 1, man_m = 0, opt_key = 0, cs_key = 0, rst_key = 0, run = 0, opt_code = 0;
  logic tap_code = 0, es_code = 0, cw_cmd = 0, ccw_cmd = 0, sys_alm = 0, estop = 1, mdi_m = 0, dnc_m = 0;
  logic [5:0] lim = 6'h3f;
  logic [2:0] hw_sel = 3'h0, hw_step = 3'h0, dly = 3'h2, hw_axis;
  logic opt_lamp, halt, sys_rst, cur_ret, es_alm, ot_alm, drv_en, ly, lg, lr;
  logic sp_sw, tap, tap_flag, tap_tmo, pos_start, pos_tmo, cw, ccw;
  logic [6:0] hw_out;
  int failures = 0, compares = 0, pulses = 0, i, j;
  logic [31:0] expq[$];

  mpil_top #(.CYC_PER_MS(5)) mpil_top_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wait_r), .IRQ_OUT(irq), .MODE_AUTO_IN(auto_m), .MODE_MDI_IN(mdi_m),
    .MODE_DNC_IN(dnc_m), .MODE_MANUAL_IN(man_m), .MODE_HANDWHEEL_IN(1'b0), .OPT_STOP_KEY_IN(opt_key),
    .CYCLE_START_KEY_IN(cs_key), .RESET_KEY_IN(rst_key), .PROGRAM_RUNNING_IN(run),
    .OPTIONAL_STOP_CODE_IN(opt_code), .RIGID_TAPPING_CODE_IN(tap_code), .EXACT_STOP_CODE_IN(es_code),
    .SPINDLE_CW_CMD_IN(cw_cmd), .SPINDLE_CCW_CMD_IN(ccw_cmd), .SYSTEM_ALARM_IN(sys_alm),
    .EMERGENCY_STOP_IN(estop), .X_NEG_LIMIT_IN(lim[0]), .X_POS_LIMIT_IN(lim[1]), .Y_NEG_LIMIT_IN(lim[2]),
    .Y_POS_LIMIT_IN(lim[3]), .Z_NEG_LIMIT_IN(lim[4]), .Z_POS_LIMIT_IN(lim[5]),
    .SPINDLE_POSITION_STATE_IN(pos_state), .POSITIONING_DONE_IN(pos_done),
    .HANDWHEEL_SEL_X_IN(hw_sel[0]), .HANDWHEEL_SEL_Y_IN(hw_sel[1]), .HANDWHEEL_SEL_Z_IN(hw_sel[2]),
    .HANDWHEEL_STEP_X1_IN(hw_step[0]), .HANDWHEEL_STEP_X10_IN(hw_step[1]),
    .HANDWHEEL_STEP_X100_IN(hw_step[2]), .OPT_STOP_LAMP_OUT(opt_lamp), .PROGRAM_HALT_OUT(halt),
    .SYSTEM_RESET_OUT(sys_rst), .CURSOR_RETURN_OUT(cur_ret), .EMERGENCY_ALARM_OUT(es_alm),
    .OVERTRAVEL_ALARM_OUT(ot_alm), .DRIVE_ENABLE_OUT(drv_en), .LAMP_YELLOW_OUT(ly), .LAMP_GREEN_OUT(lg),
    .LAMP_RED_OUT(lr), .SPEED_POSITION_SWITCH_OUT(sp_sw), .RIGID_TAPPING_OUT(tap),
    .TAPPING_DONE_FLAG_OUT(tap_flag), .TAPPING_TIMEOUT_ALARM_OUT(tap_tmo), .POSITIONING_START_OUT(pos_start),
    .POSITIONING_TIMEOUT_ALARM_OUT(pos_tmo), .SPINDLE_CW_OUT(cw), .SPINDLE_CCW_OUT(ccw),
    .HANDWHEEL_AXIS_OUT(hw_axis), .HANDWHEEL_STEP_OUT(hw_out));

  mpil_drive_model mpil_drive_model_inst (.clk_in(clk), .answer_en_in(ans_en), .delay_in(dly),
    .switch_in(sp_sw), .start_in(pos_start), .position_state_out(pos_state), .done_out(pos_done));

  initial forever #20 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // request stands until waitrequest is sampled low at a rising edge, released on that same edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (wait_r !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_exp(input logic [3:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // returns on a rising edge: outputs read here settled after n edges, stimulus then changes on it
  task automatic cyc(input int n);
    repeat (n + 1) @(posedge clk);
  endtask

  task automatic key_reset;
    rst_key <= 1'b1;
    cyc(3);
    rst_key <= 1'b0;
    cyc(2);
  endtask

  // read data taken at the rising edge at which waitrequest is sampled low
  always @(posedge clk) begin
    if (rd && wait_r === 1'b0 && expq.size() > 0) chk(rdat, expq.pop_front());
  end

  always @(negedge clk) begin
    if (tap !== tap_flag) chk(32'(tap), 32'(tap_flag));
  end

  always @(posedge clk) pulses += int'(sys_rst === 1'b1) + int'(cur_ret === 1'b1);

  initial begin
    #(40 * 20000);
    failures++;
    results;
  end

  initial begin
    void'($urandom(32'h57cca286));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk(32'(ly), 1);
    rd_exp(MPIL_ADDR_ESTOP_MASK, 32'(MPIL_ESTOP_MASK_RST));
    rd_exp(MPIL_ADDR_RESET_CFG, 32'(MPIL_RESET_CFG_RST));
    rd_exp(MPIL_ADDR_OT_CFG, 32'(MPIL_OT_CFG_RST));
    rd_exp(MPIL_ADDR_TAP_TMO, 32'(MPIL_TMO_RST));
    rd_exp(4'hf, 32'h0);
    bus(1'b1, MPIL_ADDR_TAP_TMO, 32'h2);
    bus(1'b1, MPIL_ADDR_POS_TMO, 32'h2);
    bus(1'b1, MPIL_ADDR_IRQ_MASK, 32'h3f);
    rd_exp(MPIL_ADDR_TAP_TMO, 32'h2);
    estop <= 1'b0;
    cyc(3);
    chk(32'({es_alm, drv_en, lr, ly}), 32'ha);
    chk(32'(irq), 1);
    rd_exp(MPIL_ADDR_IRQ_STAT, 32'h01);
    cyc(1);
    chk(32'(irq), 0);
    estop <= 1'b1;
    key_reset;
    chk(32'({es_alm, drv_en}), 32'h1);
    bus(1'b1, MPIL_ADDR_ESTOP_MASK, 32'h08);
    estop <= 1'b0;
    cyc(3);
    chk(32'({es_alm, drv_en}), 32'h1);
    estop <= 1'b1;
    bus(1'b1, MPIL_ADDR_ESTOP_MASK, 32'h00);
    i = $urandom % 6;
    j = (i + 1 + $urandom % 5) % 6;
    lim[i] <= 1'b0;
    cyc(3);
    chk(32'({ot_alm, lr}), 32'h3);
    lim[i] <= 1'b1;
    cyc(3);
    chk(32'(ot_alm), 1);
    key_reset;
    chk(32'(ot_alm), 0);
    bus(1'b1, MPIL_ADDR_OT_CFG, 32'h01);
    lim <= 6'h00;
    cyc(3);
    chk(32'(ot_alm), 0);
    bus(1'b1, MPIL_ADDR_OT_CFG, 32'h40);
    lim[j] <= 1'b1;
    cyc(3);
    chk(32'(ot_alm), 1);
    lim[j] <= 1'b0;
    key_reset;
    chk(32'(ot_alm), 0);
    bus(1'b1, MPIL_ADDR_OT_CFG, 32'h01);
    lim <= 6'h3f;
    bus(1'b1, MPIL_ADDR_OT_CFG, 32'h41);
    opt_key <= 1'b1;
    cyc(2);
    opt_key <= 1'b0;
    opt_code <= 1'b1;
    cyc(3);
    chk(32'({opt_lamp, halt}), 32'h3);
    opt_code <= 1'b0;
    cs_key <= 1'b1;
    cyc(2);
    cs_key <= 1'b0;
    auto_m <= 1'b0;
    man_m <= 1'b1;
    opt_key <= 1'b1;
    cyc(2);
    chk(32'({opt_lamp, halt}), 32'h2);
    opt_key <= 1'b0;
    man_m <= 1'b0;
    mdi_m <= 1'b1;
    cyc(1);
    opt_key <= 1'b1;
    cyc(1);
    chk(32'(opt_lamp), 0);
    opt_key <= 1'b0;
    mdi_m <= 1'b0;
    dnc_m <= 1'b1;
    cyc(1);
    opt_key <= 1'b1;
    cyc(1);
    chk(32'(opt_lamp), 1);
    opt_key <= 1'b0;
    dnc_m <= 1'b0;
    auto_m <= 1'b1;
    run <= 1'b1;
    cyc(2);
    chk(32'({ly, lg, lr}), 32'h2);
    run <= 1'b0;
    pulses = 0;
    key_reset;
    chk(32'(pulses), 2);
    bus(1'b1, MPIL_ADDR_RESET_CFG, 32'h00);
    estop <= 1'b0;
    cyc(2);
    estop <= 1'b1;
    pulses = 0;
    key_reset;
    chk(32'({es_alm, 7'(pulses)}), 32'h80);
    bus(1'b1, MPIL_ADDR_RESET_CFG, 32'h01);
    key_reset;
    dly <= 3'(1 + $urandom % 6);
    tap_code <= 1'b1;
    for (i = 0; i < 40 && tap_flag !== 1'b1; i++) cyc(1);
    chk(32'({sp_sw, tap, tap_flag, tap_tmo}), 32'he);
    rd_exp(MPIL_ADDR_STATUS, 32'h80);
    es_code <= 1'b1;
    cyc(2);
    chk(32'(pos_start), 0);
    es_code <= 1'b0;
    tap_code <= 1'b0;
    ans_en <= 1'b0;
    cyc(2);
    tap_code <= 1'b1;
    cyc(20);
    chk(32'({tap_tmo, tap_flag, lr}), 32'h5);
    tap_code <= 1'b0;
    ans_en <= 1'b1;
    key_reset;
    chk(32'(tap_tmo), 0);
    cw_cmd <= 1'b1;
    cyc(2);
    chk(32'(cw), 1);
    cw_cmd <= 1'b0;
    es_code <= 1'b1;
    cyc(2);
    chk(32'({pos_start, cw, ccw}), 32'h4);
    for (i = 0; i < 40 && pos_start !== 1'b0; i++) cyc(1);
    chk(32'({pos_start, pos_tmo}), 32'h0);
    es_code <= 1'b0;
    ccw_cmd <= 1'b1;
    cyc(2);
    chk(32'({pos_start, ccw}), 32'h1);
    ccw_cmd <= 1'b0;
    ans_en <= 1'b0;
    es_code <= 1'b1;
    cyc(20);
    chk(32'(pos_tmo), 1);
    es_code <= 1'b0;
    ans_en <= 1'b1;
    key_reset;
    for (i = 0; i < 9; i++) begin
      hw_sel <= 3'h1 << (i / 3);
      hw_step <= 3'h1 << (i % 3);
      cyc(2);
      chk({hw_axis, hw_out}, {22'h0, 3'h1 << (i / 3), (i % 3 == 0) ? 7'd1 : (i % 3 == 1) ? 7'd10 : 7'd100});
    end
    results;
  end
endmodule // test_mpil_top
